// file: hdl/ars_cfg.svh
`ifndef ARS_CFG_SVH
`define ARS_CFG_SVH
// -------------------------------------------------
// register byte addresses
// -------------------------------------------------
`define ARS_A_DC_A0 32'h40011490
`define ARS_A_DC_A1 32'h40011494
`define ARS_A_GC_A0 32'h40011498
`define ARS_A_GC_A1 32'h4001149c
`define ARS_A_DC_B0 32'h400114a0
`define ARS_A_DC_B1 32'h400114a4
`define ARS_A_GC_B0 32'h400114a8
`define ARS_A_GC_B1 32'h400114ac
`define ARS_A_IE 32'h400114b0
`define ARS_A_IF 32'h400114b4
`define ARS_A_SWT 32'h400114c0
`define ARS_A_TH 32'h400114c4
`define ARS_A_CFG 32'h400114c8
`define ARS_A_TRIG 32'h400114cc
`define ARS_A_CNT_LO 32'h400114d0
`define ARS_A_CNT_HI 32'h400114d4
`define ARS_A_RES0 32'h400114d8
`define ARS_A_STAT 32'h400114dc
// -------------------------------------------------
// fields and constants
// -------------------------------------------------
`define ARS_RST16 16'h0000
`define ARS_SW_KEY 16'h5aa5
`define ARS_CODE_ZERO 16'h0000
`define ARS_GAIN_FRAC 9
`define ARS_CFG_POL 1
`define ARS_CFG_FSMRST 2
`define ARS_CFG_MODE 5:4
`define ARS_MODE_ONE 2'h0
`define ARS_MODE_TWO 2'h1
`define ARS_TRIG_EN 3:0
`define ARS_TRIG_C 11:8
`define ARS_TRIG_CONT 12
`define ARS_CNT_R_LO 4:0
`define ARS_CNT_R_HI 12:8
`define ARS_CNT_FW 5
`define ARS_NFLAG 7
`define ARS_F_SERR 4
`define ARS_F_HERR 5
`define ARS_F_TH 6
`endif

// file: hdl/ars_corrector.sv
`timescale 1ns/10ps
`include "ars_cfg.svh"
module ars_corrector (
    input wire logic pclk,               // system clock
    input wire logic presetn,            // async reset, low
    input wire logic ce,                 // clock enable
    input wire logic in_valid,           // raw sample strobe
    input wire logic [15:0] raw,         // raw converter code
    input wire ars_pkg::ars_cal_t cal,   // selected set
    output logic out_valid,              // corrected strobe
    output logic [15:0] out_data         // corrected code
);
    // ---------------------------------------------
    // arithmetic
    // ---------------------------------------------
    logic [25:0] prod;         // code times gain
    logic signed [18:0] corr;  // after offset removal
    logic [15:0] next_data;    // clamped value

    // gain has nine fraction bits, dropped after product
    always_comb begin
        prod = (raw - `ARS_CODE_ZERO) * cal.gain;
        corr = $signed({2'b00, prod[25:`ARS_GAIN_FRAC]})
             - $signed({{3{cal.offset[15]}}, cal.offset});
        if (corr < 0) begin
            next_data = 16'h0000; // clamp below zero
        end else if (corr > $signed(19'h0ffff)) begin
            next_data = 16'hffff; // clamp above full scale
        end else begin
            next_data = corr[15:0];
        end
    end

    // ---------------------------------------------
    // output register
    // ---------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= `ARS_RST16;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= next_data;
            end
        end
    end
endmodule : ars_corrector

// file: hdl/ars_pkg.sv
package ars_pkg;
    // sequencer states: four idle, four sampling
    typedef enum logic [2:0] {
        st_idle0, st_idle1, st_idle2, st_idle3,
        st_samp0, st_samp1, st_samp2, st_samp3
    } ars_state_t;

    // one correction set: offset and gain factor
    typedef struct packed {
        logic [15:0] offset; // dc offset, two's complement
        logic [9:0] gain;    // 1.9 unsigned fixed point
    } ars_cal_t;
endpackage : ars_pkg

// file: hdl/ars_sequencer.sv
`timescale 1ns/10ps
`include "ars_cfg.svh"
module ars_sequencer #(
    parameter int CNT_W = 5,   // sample counter width
    parameter int EVC_W = 4    // timer event counter width
) (
    input wire logic pclk,              // 250 MHz clock
    input wire logic presetn,           // async reset, low
    input wire logic pce,               // clock enable
    input wire logic psel,              // apb select
    input wire logic penable,           // apb enable
    input wire logic pwrite,            // apb direction
    input wire logic [31:0] paddr,      // apb byte address
    input wire logic [31:0] pwdata,     // apb write data
    output logic [31:0] prdata,         // apb read data
    output logic pready,                // apb ready
    output logic pslverr,               // apb error
    input wire logic [3:0] timer_trigger_event, // timer pulses
    output logic conv_start,            // start one conversion
    input wire logic conv_done,         // conversion finished
    input wire logic [15:0] conv_data,  // raw code
    input wire logic conv_circuit_b,    // 1: circuit b used
    input wire logic conv_gain_unity,   // 1: unity gain path
    output logic res_valid,             // result strobe
    output logic [4:0] res_slot,        // result slot index
    output logic [15:0] res_data,       // corrected result
    output logic dma_req,               // dma request level
    output logic irq_level              // enabled flag pending
);
    // -------------------------------------------------
    // parameter check
    // -------------------------------------------------
    if (CNT_W < `ARS_CNT_FW || EVC_W < 4) begin : g_bad
        $error("ars_sequencer: counter widths too small");
    end

    // -------------------------------------------------
    // registers and state
    // -------------------------------------------------
    ars_pkg::ars_cal_t cal [4];     // a0, a1, b0, b1
    logic [15:0] cfg;               // polarity, mode
    logic [15:0] trig;              // enables, count, cont
    logic [15:0] cnt_lo;            // round 1 and 2 counts
    logic [15:0] cnt_hi;            // round 3 and 4 counts
    logic [6:0] ie;                 // flag enables
    logic [`ARS_NFLAG-1:0] flags;   // sticky flags
    logic [15:0] th;                // slot-0 limit
    logic [15:0] slot0;             // last slot-0 result
    ars_pkg::ars_state_t state;     // sequencer state
    ars_pkg::ars_state_t next_state;
    logic busy;                     // conversion in flight
    logic [CNT_W-1:0] samp_cnt;     // samples in round
    logic [4:0] slot;               // slot of next result
    logic [EVC_W-1:0] evcnt;        // one-round event count

    // -------------------------------------------------
    // apb decode
    // -------------------------------------------------
    logic wr_en;           // write taken this edge
    logic hit;             // address mapped
    logic [31:0] rd_val;   // read mux
    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;  // zero wait states
    assign pslverr = psel & penable & ~hit;

    // address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0;
        if (paddr == `ARS_A_DC_A0) begin
            rd_val = {16'h0, cal[0].offset};
        end else if (paddr == `ARS_A_DC_A1) begin
            rd_val = {16'h0, cal[1].offset};
        end else if (paddr == `ARS_A_DC_B0) begin
            rd_val = {16'h0, cal[2].offset};
        end else if (paddr == `ARS_A_DC_B1) begin
            rd_val = {16'h0, cal[3].offset};
        end else if (paddr == `ARS_A_GC_A0) begin
            rd_val = {22'h0, cal[0].gain};
        end else if (paddr == `ARS_A_GC_A1) begin
            rd_val = {22'h0, cal[1].gain};
        end else if (paddr == `ARS_A_GC_B0) begin
            rd_val = {22'h0, cal[2].gain};
        end else if (paddr == `ARS_A_GC_B1) begin
            rd_val = {22'h0, cal[3].gain};
        end else if (paddr == `ARS_A_IE) begin
            rd_val = {25'h0, ie};
        end else if (paddr == `ARS_A_IF) begin
            rd_val = {25'h0, flags};
        end else if (paddr == `ARS_A_SWT) begin
            rd_val = 32'h0; // write only
        end else if (paddr == `ARS_A_TH) begin
            rd_val = {16'h0, th};
        end else if (paddr == `ARS_A_CFG) begin
            rd_val = {16'h0, cfg};
        end else if (paddr == `ARS_A_TRIG) begin
            rd_val = {16'h0, trig};
        end else if (paddr == `ARS_A_CNT_LO) begin
            rd_val = {16'h0, cnt_lo};
        end else if (paddr == `ARS_A_CNT_HI) begin
            rd_val = {16'h0, cnt_hi};
        end else if (paddr == `ARS_A_RES0) begin
            rd_val = {16'h0, slot0};
        end else if (paddr == `ARS_A_STAT) begin
            rd_val = {27'h0, busy, 1'b0, state};
        end else begin
            hit = 1'b0; // unmapped
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (pce && psel && !penable && !pwrite) begin
            prdata <= rd_val;
        end
    end

    // -------------------------------------------------
    // correction set registers
    // -------------------------------------------------
    // index {circuit b, non-unity}: separate sets per path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                cal[i] <= '0;
            end
        end else if (pce && wr_en) begin
            if (paddr == `ARS_A_DC_A0) begin
                cal[0].offset <= pwdata[15:0];
            end else if (paddr == `ARS_A_DC_A1) begin
                cal[1].offset <= pwdata[15:0];
            end else if (paddr == `ARS_A_DC_B0) begin
                cal[2].offset <= pwdata[15:0];
            end else if (paddr == `ARS_A_DC_B1) begin
                cal[3].offset <= pwdata[15:0];
            end else if (paddr == `ARS_A_GC_A0) begin
                cal[0].gain <= pwdata[9:0];
            end else if (paddr == `ARS_A_GC_A1) begin
                cal[1].gain <= pwdata[9:0];
            end else if (paddr == `ARS_A_GC_B0) begin
                cal[2].gain <= pwdata[9:0];
            end else if (paddr == `ARS_A_GC_B1) begin
                cal[3].gain <= pwdata[9:0];
            end
        end
    end

    // -------------------------------------------------
    // control registers
    // -------------------------------------------------
    logic fsm_rst;   // sequencer reset pulse
    logic sw_trig;   // key written to trigger register
    assign fsm_rst = wr_en && paddr == `ARS_A_CFG
        && pwdata[`ARS_CFG_FSMRST];
    assign sw_trig = wr_en && paddr == `ARS_A_SWT
        && pwdata[15:0] == `ARS_SW_KEY;

    // config, trigger, count, enable and limit registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `ARS_RST16;
            trig <= `ARS_RST16;
            cnt_lo <= `ARS_RST16;
            cnt_hi <= `ARS_RST16;
            ie <= 7'h0;
            th <= `ARS_RST16;
        end else if (pce && wr_en) begin
            if (paddr == `ARS_A_CFG) begin
                cfg <= pwdata[15:0];
                cfg[`ARS_CFG_FSMRST] <= 1'b0; // self clearing
            end else if (paddr == `ARS_A_TRIG) begin
                trig <= pwdata[15:0];
            end else if (paddr == `ARS_A_CNT_LO) begin
                cnt_lo <= pwdata[15:0];
            end else if (paddr == `ARS_A_CNT_HI) begin
                cnt_hi <= pwdata[15:0];
            end else if (paddr == `ARS_A_IE) begin
                ie <= pwdata[6:0];
            end else if (paddr == `ARS_A_TH) begin
                th <= pwdata[15:0];
            end
        end
    end

    // -------------------------------------------------
    // trigger qualification
    // -------------------------------------------------
    logic [3:0] ev;       // enabled timer events
    logic idle;           // any idle state
    logic one_mode;       // one-round mode
    logic two_mode;       // two-round mode
    logic cont;           // continuous sampling
    logic ev_fire;        // counted one-round trigger
    logic start;          // round trigger accepted
    assign ev = timer_trigger_event & trig[`ARS_TRIG_EN];
    assign idle = state inside {ars_pkg::st_idle0,
        ars_pkg::st_idle1, ars_pkg::st_idle2,
        ars_pkg::st_idle3};
    assign one_mode = cfg[`ARS_CFG_MODE] == `ARS_MODE_ONE;
    assign two_mode = cfg[`ARS_CFG_MODE] == `ARS_MODE_TWO;
    assign cont = trig[`ARS_TRIG_CONT] & one_mode;
    // count reached: c of 0 or 1 fires on the first event
    assign ev_fire = (|ev) && ({1'b0, evcnt} + 1'b1
        >= {1'b0, trig[`ARS_TRIG_C]});

    // per idle state, which trigger may start the round
    always_comb begin
        start = 1'b0;
        case (state)
            ars_pkg::st_idle0: begin
                start = sw_trig | cont |
                    (one_mode ? ev_fire : ev[0]);
            end
            ars_pkg::st_idle1: begin
                start = sw_trig | ev[1];
            end
            ars_pkg::st_idle2: begin
                start = sw_trig | ev[2];
            end
            ars_pkg::st_idle3: begin
                start = sw_trig | ev[3];
            end
            default: begin
                start = 1'b0; // sampling ignores triggers
            end
        endcase
    end

    // timer events counted for one-round mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evcnt <= '0;
        end else if (pce) begin
            if (fsm_rst || start || !one_mode
                || state != ars_pkg::st_idle0) begin
                evcnt <= '0;
            end else if (|ev) begin
                evcnt <= evcnt + 1'b1;
            end
        end
    end

    // -------------------------------------------------
    // round progress
    // -------------------------------------------------
    logic corr_valid;          // corrected result strobe
    logic [15:0] corr_data;    // corrected result
    logic [4:0] target;        // samples in this round
    logic round_end;           // last sample corrected
    always_comb begin
        case (state)
            ars_pkg::st_samp0: target = cnt_lo[`ARS_CNT_R_LO];
            ars_pkg::st_samp1: target = cnt_lo[`ARS_CNT_R_HI];
            ars_pkg::st_samp2: target = cnt_hi[`ARS_CNT_R_LO];
            default: target = cnt_hi[`ARS_CNT_R_HI];
        endcase
    end
    // a count of zero behaves as one sample
    assign round_end = corr_valid && !idle && (samp_cnt
        + 1'b1 >= CNT_W'(target));

    // -------------------------------------------------
    // sequencer state machine
    // -------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ars_pkg::st_idle0: begin
                if (start) next_state = ars_pkg::st_samp0;
            end
            ars_pkg::st_idle1: begin
                if (start) next_state = ars_pkg::st_samp1;
            end
            ars_pkg::st_idle2: begin
                if (start) next_state = ars_pkg::st_samp2;
            end
            ars_pkg::st_idle3: begin
                if (start) next_state = ars_pkg::st_samp3;
            end
            ars_pkg::st_samp0: begin
                if (round_end && one_mode) begin
                    next_state = cont ? ars_pkg::st_samp0
                        : ars_pkg::st_idle0;
                end else if (round_end) begin
                    next_state = ars_pkg::st_idle1;
                end
            end
            ars_pkg::st_samp1: begin
                if (round_end) begin
                    next_state = two_mode ? ars_pkg::st_idle0
                        : ars_pkg::st_idle2;
                end
            end
            ars_pkg::st_samp2: begin
                if (round_end) next_state = ars_pkg::st_idle3;
            end
            default: begin
                if (round_end) next_state = ars_pkg::st_idle0;
            end
        endcase
    end

    // state register, sequencer reset forces idle 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ars_pkg::st_idle0;
        end else if (pce) begin
            if (fsm_rst) begin
                state <= ars_pkg::st_idle0;
            end else begin
                state <= next_state;
            end
        end
    end

    // conversion issue, sample and slot counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            conv_start <= 1'b0;
            samp_cnt <= '0;
            slot <= 5'h0;
        end else if (pce) begin
            conv_start <= 1'b0;
            if (fsm_rst) begin
                busy <= 1'b0;
                samp_cnt <= '0;
                slot <= 5'h0;
            end else if (start) begin
                samp_cnt <= '0;
                if (state == ars_pkg::st_idle0) slot <= 5'h0;
            end else if (round_end) begin
                busy <= 1'b0;
                samp_cnt <= '0;
                slot <= (next_state == ars_pkg::st_samp0)
                    ? 5'h0 : slot + 1'b1;
            end else if (corr_valid) begin
                busy <= 1'b0;
                samp_cnt <= samp_cnt + 1'b1;
                slot <= slot + 1'b1;
            end else if (!idle && !busy) begin
                busy <= 1'b1;
                conv_start <= 1'b1;
            end
        end
    end

    // -------------------------------------------------
    // correction path
    // -------------------------------------------------
    ars_corrector u_corr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(pce),
        .in_valid(conv_done & busy),
        .raw(conv_data),
        .cal(cal[{conv_circuit_b, ~conv_gain_unity}]),
        .out_valid(corr_valid),
        .out_data(corr_data)
    );
    assign res_valid = corr_valid;
    assign res_data = corr_data;
    assign res_slot = slot;

    // -------------------------------------------------
    // slot 0 and threshold
    // -------------------------------------------------
    logic th_hit;   // slot-0 result beyond limit
    assign th_hit = corr_valid && slot == 5'h0 &&
        (cfg[`ARS_CFG_POL] ? (corr_data > th)
                           : (corr_data < th));

    // slot-0 result copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot0 <= `ARS_RST16;
        end else if (pce && corr_valid && slot == 5'h0) begin
            slot0 <= corr_data;
        end
    end

    // -------------------------------------------------
    // flags
    // -------------------------------------------------
    logic [`ARS_NFLAG-1:0] fset;   // events this cycle
    logic [`ARS_NFLAG-1:0] fclr;   // write-one clears
    always_comb begin
        fset = '0;
        if (round_end) begin
            case (state)
                ars_pkg::st_samp0: fset[0] = 1'b1;
                ars_pkg::st_samp1: fset[1] = 1'b1;
                ars_pkg::st_samp2: fset[2] = 1'b1;
                default: fset[3] = 1'b1;
            endcase
        end
        fset[`ARS_F_SERR] = sw_trig & ~idle;
        fset[`ARS_F_HERR] = (|ev) & ~idle;
        fset[`ARS_F_TH] = th_hit;
        fclr = (wr_en && paddr == `ARS_A_IF)
            ? pwdata[`ARS_NFLAG-1:0] : '0;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else if (pce) begin
            flags <= (flags & ~fclr) | fset;
        end
    end

    assign dma_req = flags[0];
    assign irq_level = |(flags & ie);
endmodule : ars_sequencer

// file: tb/adc_round_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "ars_cfg.svh"
module adc_round_sequencer_tb_top;
    typedef struct {logic [31:0] a, d, e;} ars_row_t;
    localparam logic [31:0] F = 32'hffffffff; // all ones
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, q;
    logic pready, pslverr, conv_start, conv_done, cb, cu;
    logic res_valid, dma_req, irq_level;
    logic [3:0] ev = 0; // timer pulses
    logic [4:0] res_slot;
    logic [15:0] res_data, cd;
    logic [17:0] code = 0; // raw sample the converter returns
    int bad_count = 0, checked = 0, k;
    ars_row_t rows[6] = '{'{`ARS_A_GC_B0, F, 32'h3ff},
        '{`ARS_A_GC_B1, F, 32'h3ff}, '{`ARS_A_TH, F, 32'hffff},
        '{`ARS_A_IF, F, 0}, '{`ARS_A_SWT, 32'h1234, 0},
        '{32'h400114bc, F, 0}};
    ars_row_t cfg[7] = '{'{`ARS_A_GC_B0, 32'h300, 0},
        '{`ARS_A_DC_B0, 32'h10, 0}, '{`ARS_A_GC_A1, 32'h200, 0},
        '{`ARS_A_DC_A1, 32'h5, 0}, '{`ARS_A_TH, 32'h100, 0},
        '{`ARS_A_CFG, 32'h2, 0}, '{`ARS_A_CNT_LO, 32'h201, 0}};
    always #2 pclk = ~pclk;
    ars_sequencer i_dut (.pclk, .presetn, .pce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .timer_trigger_event(ev), .conv_start, .conv_done,
        .conv_data(cd), .conv_circuit_b(cb), .conv_gain_unity(cu),
        .res_valid, .res_slot, .res_data, .dma_req, .irq_level);
    ars_conv_model #(.DLY(20)) i_conv (.pclk, .presetn, .conv_start,
        .code, .conv_done, .conv_data(cd), .conv_circuit_b(cb),
        .conv_gain_unity(cu));
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : ck
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    // waits at least one edge, so a second call finds the next result
    task automatic wres;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (k < 300 && res_valid !== 1'b1);
        ck(res_valid, 1);
    endtask : wres
    task automatic fire(input int n);
        ev <= 4'h1 << n;
        @(posedge pclk);
        ev <= 4'h0;
        @(posedge pclk);
    endtask : fire
    task automatic give_verdict;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            ck(q, 0);
            apb(1, rows[i].a, rows[i].d);
            apb(0, rows[i].a, 0);
            ck(q, rows[i].e);
        end
        ck(er, 1);
        foreach (cfg[i]) apb(1, cfg[i].a, cfg[i].d);
        code <= 18'h30100;
        apb(1, `ARS_A_SWT, 32'h5aa5);
        wres();
        ck({16'h0, res_data}, 32'h170);
        @(posedge pclk);
        ck(dma_req, 1);
        apb(0, `ARS_A_IF, 0);
        ck(q, 32'h41);
        apb(1, `ARS_A_IF, 32'h41);
        ck(dma_req, 0);
        apb(1, `ARS_A_CFG, 32'h12);
        apb(1, `ARS_A_TRIG, 32'h3);
        code <= 18'h00100;
        fire(0);
        apb(1, `ARS_A_SWT, 32'h5aa5);
        wres();
        ck({16'h0, res_data}, 32'hfb);
        apb(0, `ARS_A_STAT, 0);
        ck(q & 32'h7, 1);
        fire(1);
        wres();
        wres();
        ck(res_slot, 2);
        apb(0, `ARS_A_STAT, 0);
        ck(q & 32'h7, 0);
        apb(0, `ARS_A_IF, 0);
        ck(q, 32'h13);
        apb(1, `ARS_A_IF, 32'h7f);
        apb(1, `ARS_A_TRIG, 0);
        apb(1, `ARS_A_CFG, 32'h20);
        apb(1, `ARS_A_CNT_LO, 32'h101);
        apb(1, `ARS_A_CNT_HI, 32'h101);
        for (int r = 0; r < 4; r++) begin
            apb(1, `ARS_A_SWT, 32'h5aa5);
            wres();
            ck(res_slot, r);
            apb(0, `ARS_A_STAT, 0);
            ck(q & 32'h7, (r + 1) % 4);
        end
        apb(0, `ARS_A_IF, 0);
        ck(q, 32'h4f);
        apb(1, `ARS_A_SWT, 32'h5aa5);
        apb(1, `ARS_A_CFG, 32'h24);
        apb(0, `ARS_A_STAT, 0);
        ck(q & 32'h7, 0);
        repeat (30) @(posedge pclk);
        apb(1, `ARS_A_CFG, 32'h0);
        apb(1, `ARS_A_TRIG, 32'h304);
        fire(2);
        fire(2);
        apb(0, `ARS_A_STAT, 0);
        ck(q & 32'h7, 0);
        fire(2);
        wres();
        ck({16'h0, res_data}, 32'hfb);
        apb(1, `ARS_A_IF, 32'h7f);
        apb(1, `ARS_A_IE, 32'h1);
        apb(1, `ARS_A_TRIG, 32'h1000);
        wres();
        ck(res_slot, 0);
        @(posedge pclk);
        ck(irq_level, 1);
        apb(1, `ARS_A_IF, 32'h1);
        ck(irq_level, 0);
        wres();
        ck(res_slot, 0);
        @(posedge pclk);
        ck(irq_level, 1);
        apb(1, `ARS_A_TRIG, 0);
        give_verdict();
    end
endmodule : adc_round_sequencer_tb_top
bind ars_sequencer ars_asserts i_chk (.pclk, .presetn, .pce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conv_start, .conv_done, .res_valid, .dma_req);

// file: tb/ars_asserts.sv
`timescale 1ns/10ps
`include "ars_cfg.svh"
module ars_asserts (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic pce, // clock enable
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [31:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic conv_start, // start pulse
    input wire logic conv_done, // done pulse
    input wire logic res_valid, // result strobe
    input wire logic dma_req // dma level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (psel && penable |-> pready)
        else $error("ready low in access");
    chk_unmap_err: assert property (psel && penable &&
        paddr == 32'h400114bc |-> pslverr) else $error("no error");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    chk_res_cause: assert property (res_valid |-> $past(conv_done))
        else $error("result without conversion");
    chk_dma_cause: assert property ($rose(dma_req) |-> $past(res_valid))
        else $error("dma without round end");
    chk_start_gap: assert property (res_valid |=> !conv_start)
        else $error("start too soon");
    chk_flag_clear: assert property (pce && psel && penable && pwrite &&
        paddr == `ARS_A_IF && pwdata[0] && !res_valid |=> !dma_req)
        else $error("flag not cleared");
    chk_key_read: assert property (pce && psel && !penable && !pwrite &&
        paddr == `ARS_A_SWT |=> prdata == 32'h0) else $error("key readable");
    cov_result: cover property (res_valid);
    cov_dma: cover property ($rose(dma_req));
    cov_err: cover property (pslverr);
endmodule : ars_asserts

// file: tb/ars_conv_model.sv
`timescale 1ns/10ps
module ars_conv_model #(parameter int DLY = 20) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic conv_start, // start pulse
    input wire logic [17:0] code, // circuit b, unity, raw
    output logic conv_done, // done pulse
    output logic [15:0] conv_data, // raw code
    output logic conv_circuit_b, // circuit b used
    output logic conv_gain_unity // unity path
);
    int cnt; // cycles left in conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt <= 0;
        else if (conv_start) cnt <= DLY;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign conv_done = (cnt == 1);
    // outside done the lines carry garbage, not the last value
    assign {conv_circuit_b, conv_gain_unity, conv_data} =
        conv_done ? code : ~code;
endmodule : ars_conv_model
